// >>> core/dfc_pkg.sv
package dfc_pkg;
  // Register byte addresses within the receiver window.
  localparam logic [15:0] COMB2_DEC_LO_ADDR = 16'h1830;
  localparam logic [15:0] COMB2_DEC_HI_ADDR = 16'h1834;
  localparam logic [15:0] COMB5_DEC_LO_ADDR = 16'h1840;
  localparam logic [15:0] COMB5_DEC_HI_ADDR = 16'h1844;
  localparam logic [15:0] OUT_CTRL_LO_ADDR = 16'h1848;
  localparam logic [15:0] OUT_CTRL_HI_ADDR = 16'h184c;
  localparam logic [15:0] FIR_DEC_LO_ADDR = 16'h1850;
  localparam logic [15:0] FIR_DEC_HI_ADDR = 16'h1854;
  localparam logic [15:0] COEF_BASE_LO_ADDR = 16'h1858;
  localparam logic [15:0] COEF_BASE_HI_ADDR = 16'h185c;
  localparam logic [15:0] TAP_COUNT_LO_ADDR = 16'h1860;
  localparam logic [15:0] TAP_COUNT_HI_ADDR = 16'h1864;
  localparam logic [15:0] STATUS_ADDR = 16'h1870;
  localparam logic [15:0] COEF_MEM_ADDR = 16'h1400;
  localparam logic [5:0] COEF_MEM_PAGE = 6'h05;
  // Field positions and reset values.
  localparam int SCALE_MSB = 2;
  localparam int STATUS_BUSY_BIT = 16;
  localparam logic [7:0] DEC_RESET = 8'h00;
  localparam logic [2:0] SCALE_RESET = 3'h0;
  localparam logic [7:0] BASE_RESET = 8'h00;
  localparam logic [7:0] TAPS_RESET = 8'h00;
  // Datapath widths.
  localparam int IN_W = 16;
  localparam int STAGE_W = 18;
  localparam int COMB2_ACC_W = 26;
  localparam int COMB5_ACC_W = 43;
  localparam int COEF_W = 20;
  localparam int MEM_DEPTH = 256;
  localparam int FIR_ACC_W = 46;
  localparam int FIR_RES_W = 23;
  localparam int FIR_RES_LSB = 19;
  localparam int OUT_W = 16;
  localparam int ROUND_DROP = 8;
  localparam logic signed [31:0] ROUND_HALF = 32'sh00000080;
  localparam logic signed [31:0] SAT_MAX = 32'sh00007fff;
  localparam logic signed [31:0] SAT_MIN = -32'sh00008000;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_MAC = 3'b010,
    ST_OUT = 3'b100
  } dfc_fir_state_t;
endpackage

// >>> core/dfc_cic.sv
`timescale 1ns/100ps
module dfc_cic
  import dfc_pkg::*;
#(
  parameter int ORDER = 2,
  parameter int DIN_W = 16,
  parameter int ACC_W = 26,
  parameter int DOUT_W = 18
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Sample input and rate setting.
  input wire logic in_valid_i,
  input wire logic signed [DIN_W-1:0] in_data_i,
  input wire logic [7:0] dec_m1_i,
  // Decimated output.
  output logic out_valid_o,
  output logic signed [DOUT_W-1:0] out_data_o
);
  logic signed [ACC_W-1:0] integ_w [0:ORDER];
  logic signed [ACC_W-1:0] integ_q [1:ORDER];
  logic signed [ACC_W-1:0] comb_w [0:ORDER];
  logic signed [ACC_W-1:0] dly_q [1:ORDER];
  logic [7:0] cnt_q;
  wire last_w = in_valid_i && (cnt_q >= dec_m1_i);

  assign integ_w[0] = ACC_W'(in_data_i);
  assign comb_w[0] = integ_w[ORDER];

  genvar g;
  generate
    for (g = 1; g <= ORDER; g++) begin : g_stage
      assign integ_w[g] = integ_q[g];
      assign comb_w[g] = comb_w[g-1] - dly_q[g];
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          integ_q[g] <= '0;
          dly_q[g] <= '0;
        end else begin
          if (in_valid_i) begin
            integ_q[g] <= integ_w[g] + integ_w[g-1];
          end
          if (last_w) begin
            dly_q[g] <= comb_w[g-1];
          end
        end
      end
    end
  endgenerate

  // The counter starts cleared, so the first output follows dec_m1+1 inputs.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= DEC_RESET;
      out_valid_o <= 1'b0;
      out_data_o <= '0;
    end else begin
      out_valid_o <= last_w;
      if (in_valid_i) begin
        cnt_q <= last_w ? 8'h00 : cnt_q + 8'h01;
      end
      if (last_w) begin
        out_data_o <= comb_w[ORDER][ACC_W-1 -: DOUT_W];
      end
    end
  end
endmodule

// >>> core/dfc_filter_top.sv
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module dfc_filter_top
  import dfc_pkg::*;
(
  // Clock and reset.
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // AHB-Lite slave.
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  // Sample input.
  input wire logic SAMPLE_VALID_I,
  input wire logic signed [IN_W-1:0] SAMPLE_DATA_I,
  // Filtered output.
  output logic OUT_VALID_O,
  output logic signed [OUT_W-1:0] OUT_WORD_O
);
  // Configuration registers.
  logic [7:0] comb2_dec_q;
  logic [7:0] comb5_dec_q;
  logic [2:0] scale_q;
  logic [7:0] fir_dec_q;
  logic [7:0] coef_base_q;
  logic [7:0] taps_m1_q;

  // Bus state.
  logic wr_pend_q;
  logic [15:0] wr_addr_q;
  logic rd_wait_q;
  logic [15:0] rd_addr_q;
  logic [31:0] rdata_q;

  // Memories.
  logic signed [COEF_W-1:0] coef_mem [0:MEM_DEPTH-1];
  logic signed [STAGE_W-1:0] data_mem [0:MEM_DEPTH-1];
  logic [7:0] wr_ptr_q;

  // Stage links.
  logic c2_valid;
  logic signed [STAGE_W-1:0] c2_data;
  logic c5_valid;
  logic signed [STAGE_W-1:0] c5_data;

  // FIR sequencer.
  dfc_fir_state_t state_q;
  logic [7:0] fir_cnt_q;
  logic [7:0] newest_q;
  logic [7:0] tap_q;
  logic signed [FIR_ACC_W-1:0] acc_q;
  logic [OUT_W-1:0] last_word_q;

  // Address phase decode.
  wire addr_ph = HSEL_I && HTRANS_I[1] && HREADY_I;
  wire wr_start = addr_ph && HWRITE_I;
  wire rd_start = addr_ph && !HWRITE_I;
  wire [15:0] haddr_lo = HADDR_I[15:0];

  // Data phase write decode.
  wire wr_en = wr_pend_q;
  wire wr_comb2 = wr_en && (wr_addr_q == COMB2_DEC_LO_ADDR);
  wire wr_comb5 = wr_en && (wr_addr_q == COMB5_DEC_LO_ADDR);
  wire wr_scale = wr_en && (wr_addr_q == OUT_CTRL_LO_ADDR);
  wire wr_fir_dec = wr_en && (wr_addr_q == FIR_DEC_LO_ADDR);
  wire wr_base = wr_en && (wr_addr_q == COEF_BASE_LO_ADDR);
  wire wr_taps = wr_en && (wr_addr_q == TAP_COUNT_LO_ADDR);
  wire wr_coef = wr_en && (wr_addr_q[15:10] == COEF_MEM_PAGE);
  wire [7:0] wr_coef_idx = wr_addr_q[9:2];

  // Read decode; high words and holes read as zero.
  wire rd_is_coef = (rd_addr_q[15:10] == COEF_MEM_PAGE);
  wire [7:0] rd_coef_idx = rd_addr_q[9:2];
  wire busy = (state_q != ST_IDLE);
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    if (rd_is_coef) begin
      rd_mux = {12'h000, coef_mem[rd_coef_idx]};
    end else begin
      case (rd_addr_q)
        COMB2_DEC_LO_ADDR: rd_mux = {24'h000000, comb2_dec_q};
        COMB5_DEC_LO_ADDR: rd_mux = {24'h000000, comb5_dec_q};
        OUT_CTRL_LO_ADDR: rd_mux = {29'h00000000, scale_q};
        FIR_DEC_LO_ADDR: rd_mux = {24'h000000, fir_dec_q};
        COEF_BASE_LO_ADDR: rd_mux = {24'h000000, coef_base_q};
        TAP_COUNT_LO_ADDR: rd_mux = {24'h000000, taps_m1_q};
        STATUS_ADDR: rd_mux = {15'h0000, busy, last_word_q};
        default: rd_mux = 32'h00000000;
      endcase
    end
  end

  // Reads take one wait state so that a write in the preceding data phase is seen.
  assign HREADYOUT_O = !rd_wait_q;
  assign HRESP_O = 1'b0;
  assign HRDATA_O = rdata_q;

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 16'h0000;
      rd_wait_q <= 1'b0;
      rd_addr_q <= 16'h0000;
      rdata_q <= 32'h00000000;
    end else begin
      if (HREADY_I) begin
        wr_pend_q <= wr_start;
        wr_addr_q <= haddr_lo;
      end else begin
        wr_pend_q <= 1'b0;
      end
      rd_wait_q <= rd_start;
      if (rd_start) begin
        rd_addr_q <= haddr_lo;
      end
      if (rd_wait_q) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // Only the low byte, or the low three bits, of each setting is stored.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      comb2_dec_q <= DEC_RESET;
      comb5_dec_q <= DEC_RESET;
      scale_q <= SCALE_RESET;
      fir_dec_q <= DEC_RESET;
      coef_base_q <= BASE_RESET;
      taps_m1_q <= TAPS_RESET;
    end else begin
      if (wr_comb2) comb2_dec_q <= HWDATA_I[7:0];
      if (wr_comb5) comb5_dec_q <= HWDATA_I[7:0];
      if (wr_scale) scale_q <= HWDATA_I[SCALE_MSB:0];
      if (wr_fir_dec) fir_dec_q <= HWDATA_I[7:0];
      if (wr_base) coef_base_q <= HWDATA_I[7:0];
      if (wr_taps) taps_m1_q <= HWDATA_I[7:0];
    end
  end

  // Memory contents are not cleared at reset, which keeps them as plain RAM.
  always_ff @(posedge CLK_I) begin
    if (wr_coef) begin
      coef_mem[wr_coef_idx] <= HWDATA_I[COEF_W-1:0];
    end
    if (c5_valid) begin
      data_mem[wr_ptr_q] <= c5_data;
    end
  end

  dfc_cic #(
    .ORDER(2),
    .DIN_W(IN_W),
    .ACC_W(COMB2_ACC_W),
    .DOUT_W(STAGE_W)
  ) u_comb2 (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .in_valid_i(SAMPLE_VALID_I),
    .in_data_i(SAMPLE_DATA_I),
    .dec_m1_i(comb2_dec_q),
    .out_valid_o(c2_valid),
    .out_data_o(c2_data)
  );

  dfc_cic #(
    .ORDER(5),
    .DIN_W(STAGE_W),
    .ACC_W(COMB5_ACC_W),
    .DOUT_W(STAGE_W)
  ) u_comb5 (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .in_valid_i(c2_valid),
    .in_data_i(c2_data),
    .dec_m1_i(comb5_dec_q),
    .out_valid_o(c5_valid),
    .out_data_o(c5_data)
  );

  // FIR decimation: a computation starts after every fir_dec+1 stage samples.
  wire fir_last = c5_valid && (fir_cnt_q >= fir_dec_q);
  wire start = fir_last && (state_q == ST_IDLE);
  wire [7:0] coef_idx = coef_base_q + tap_q;
  wire [7:0] data_idx = newest_q - tap_q;
  wire signed [COEF_W+STAGE_W-1:0] product = coef_mem[coef_idx] * data_mem[data_idx];
  wire last_tap = (tap_q == taps_m1_q);

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      fir_cnt_q <= DEC_RESET;
      wr_ptr_q <= 8'h00;
    end else if (c5_valid) begin
      fir_cnt_q <= fir_last ? 8'h00 : fir_cnt_q + 8'h01;
      wr_ptr_q <= wr_ptr_q + 8'h01;
    end
  end

  // One tap per clock; a decimation point that lands while busy is dropped.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_q <= ST_IDLE;
      newest_q <= 8'h00;
      tap_q <= 8'h00;
      acc_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            state_q <= ST_MAC;
            newest_q <= wr_ptr_q;
            tap_q <= 8'h00;
            acc_q <= '0;
          end
        end
        ST_MAC: begin
          acc_q <= acc_q + FIR_ACC_W'(product);
          tap_q <= tap_q + 8'h01;
          if (last_tap) begin
            state_q <= ST_OUT;
          end
        end
        ST_OUT: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Scale by 2^s, round half up, saturate to the output width.
  wire signed [FIR_RES_W-1:0] fir_result = acc_q[FIR_RES_LSB+FIR_RES_W-1:FIR_RES_LSB];
  wire signed [31:0] scaled = 32'(fir_result) <<< scale_q;
  wire signed [31:0] rounded = (scaled + ROUND_HALF) >>> ROUND_DROP;
  wire signed [OUT_W-1:0] out_word = (rounded > SAT_MAX) ? OUT_W'(SAT_MAX) :
                                     (rounded < SAT_MIN) ? OUT_W'(SAT_MIN) : OUT_W'(rounded);

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      OUT_VALID_O <= 1'b0;
      OUT_WORD_O <= '0;
      last_word_q <= 16'h0000;
    end else begin
      OUT_VALID_O <= (state_q == ST_OUT);
      if (state_q == ST_OUT) begin
        OUT_WORD_O <= out_word;
        last_word_q <= out_word;
      end
    end
  end
endmodule

// >>> dv/dfc_filter_asserts.sv
`timescale 1ns/100ps
module dfc_filter_asserts (
  // Clock, reset and bus.
  input wire logic CLK_I, RST_N_I, HSEL_I, HWRITE_I, HREADY_I, HREADYOUT_O, HRESP_O,
  input wire logic [1:0] HTRANS_I,
  input wire logic [31:0] HRDATA_O,
  // Sample path.
  input wire logic SAMPLE_VALID_I, OUT_VALID_O,
  input wire logic signed [15:0] OUT_WORD_O
);
  logic [8:0] idle_q;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  // A result can only follow a sample by the longest tap run plus pipeline slack.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) idle_q <= 9'h000;
    else if (SAMPLE_VALID_I) idle_q <= 9'h000;
    else if (idle_q != 9'h1ff) idle_q <= idle_q + 9'h001;
  end
  sequence s_take; HSEL_I && HTRANS_I[1] && HREADY_I; endsequence
  sequence s_wait; !HREADYOUT_O ##1 HREADYOUT_O; endsequence
  chk_read_wait: assert property (s_take ##0 !HWRITE_I |=> s_wait)
    else $error("read wait state wrong");
  chk_write_nowait: assert property (s_take ##0 HWRITE_I |=> HREADYOUT_O)
    else $error("write stalled");
  chk_wait_cause: assert property (!HREADYOUT_O |-> $past(HSEL_I && HTRANS_I[1] && HREADY_I && !HWRITE_I))
    else $error("stall without read");
  chk_rdata_hold: assert property (HREADYOUT_O && $past(HREADYOUT_O) |-> $stable(HRDATA_O))
    else $error("read data moved");
  chk_resp_okay: assert property (HRESP_O == 1'b0)
    else $error("error response");
  chk_valid_pulse: assert property (OUT_VALID_O |=> !OUT_VALID_O)
    else $error("output strobe too long");
  chk_word_hold: assert property (!OUT_VALID_O |-> $stable(OUT_WORD_O))
    else $error("output word changed");
  chk_out_cause: assert property (OUT_VALID_O |-> idle_q < 9'h10e)
    else $error("output without samples");
endmodule
bind dfc_filter_top dfc_filter_asserts u_chk (.CLK_I, .RST_N_I, .HSEL_I, .HWRITE_I, .HREADY_I, .HREADYOUT_O,
  .HRESP_O, .HTRANS_I, .HRDATA_O, .SAMPLE_VALID_I, .OUT_VALID_O, .OUT_WORD_O);

// >>> dv/tb.sv
`timescale 1ns/100ps
module tb;
  import dfc_pkg::*;
  logic CLK_I = 1'b0;
  logic RST_N_I = 1'b0;
  logic HSEL_I = 1'b0;
  logic HWRITE_I = 1'b0;
  logic SAMPLE_VALID_I = 1'b0;
  logic [1:0] HTRANS_I = 2'h0;
  logic [2:0] HSIZE_I = 3'h2;
  logic [31:0] HADDR_I = 32'h0;
  logic [31:0] HWDATA_I = 32'h0;
  logic signed [15:0] SAMPLE_DATA_I = 16'sh03e8;
  logic [31:0] HRDATA_O;
  logic HREADYOUT_O, HRESP_O, OUT_VALID_O;
  logic signed [15:0] OUT_WORD_O;
  int n_errors = 0;
  int checks_done = 0;
  int n_out = 0;
  dfc_filter_top dut (.CLK_I, .RST_N_I, .HSEL_I, .HADDR_I, .HTRANS_I, .HWRITE_I, .HSIZE_I, .HWDATA_I,
    .HREADY_I(HREADYOUT_O), .HRDATA_O, .HREADYOUT_O, .HRESP_O, .SAMPLE_VALID_I, .SAMPLE_DATA_I,
    .OUT_VALID_O, .OUT_WORD_O);
  initial begin
    forever #25 CLK_I = ~CLK_I;
  end
  always @(negedge CLK_I) begin
    if (OUT_VALID_O === 1'b1) n_out++;
  end
  task final_report;
    $display("mismatches %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Ready is looked at mid-cycle, which equals its value at the next rising edge.
  task automatic rdy;
    int n;
    n = 0;
    do begin
      @(negedge CLK_I);
      n++;
    end while (HREADYOUT_O !== 1'b1 && n < 20);
    if (HREADYOUT_O !== 1'b1) begin
      n_errors++;
      final_report();
    end
  endtask
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] r);
    HSEL_I <= 1'b1;
    HTRANS_I <= 2'h2;
    HWRITE_I <= w;
    HADDR_I <= {16'h0000, a};
    rdy();
    @(posedge CLK_I);
    HSEL_I <= 1'b0;
    HTRANS_I <= 2'h0;
    HWDATA_I <= d;
    rdy();
    r = HRDATA_O;
    @(posedge CLK_I);
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rdc(input logic [15:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  task automatic send(input int n);
    repeat (n) begin
      SAMPLE_VALID_I <= 1'b1;
      @(posedge CLK_I);
      SAMPLE_VALID_I <= 1'b0;
      @(posedge CLK_I);
    end
    repeat (12) @(posedge CLK_I);
  endtask
  function automatic int eo(input int r, input int s);
    return (r * (2 ** s) + 128) / 256;
  endfunction
  task automatic t_regs;
    logic [15:0] a [6] = '{16'h1830, 16'h1840, 16'h1848, 16'h1850, 16'h1858, 16'h1860};
    logic [31:0] m;
    foreach (a[i]) begin
      m = (a[i] == 16'h1848) ? 32'h7 : 32'hff;
      rdc(a[i], 32'h0);
      wr(a[i], (m == 32'h7) ? m : 32'hffffffff);
      rdc(a[i], m);
      wr(a[i] + 16'h0004, 32'hffff);
      rdc(a[i] + 16'h0004, 32'h0);
    end
    rdc(16'h1868, 32'h0);
  endtask
  task automatic t_chain;
    wr(16'h1830, 32'hf);
    wr(16'h1840, 32'h1f);
    wr(16'h1848, 32'h0);
    wr(16'h1850, 32'h0);
    wr(16'h1858, 32'h0);
    wr(16'h1860, 32'h0);
    wr(16'h1400, 32'h40000);
    wr(16'h1414, 32'h20000);
    wr(16'h1418, 32'h20000);
    rdc(16'h1414, 32'h00020000);
    n_out = 0;
    send(5120);
    chk(32'(n_out), 32'd10);
    chk({16'h0000, OUT_WORD_O}, 32'(eo(500, 0)));
  endtask
  task automatic t_scale;
    for (int s = 0; s < 8; s++) begin
      wr(16'h1848, 32'(s));
      send(1024);
      chk({16'h0000, OUT_WORD_O}, 32'(eo(500, s)));
    end
  endtask
  task automatic t_fir;
    wr(16'h1858, 32'h5);
    send(1024);
    chk({16'h0000, OUT_WORD_O}, 32'(eo(250, 7)));
    wr(16'h1860, 32'h1);
    send(1024);
    chk({16'h0000, OUT_WORD_O}, 32'(eo(500, 7)));
    wr(16'h1850, 32'h1);
    n_out = 0;
    send(2048);
    chk(32'(n_out), 32'd2);
    rdc(16'h1870, 32'h000000fa);
  endtask
  initial begin
    repeat (10) @(posedge CLK_I);
    RST_N_I <= 1'b1;
    @(posedge CLK_I);
    t_regs();
    t_chain();
    t_scale();
    t_fir();
    final_report();
  end
endmodule
